// ---- core/timer2_capture_reload_baud.v ----
`timescale 1ns/1ps
`include "timer2_defs.vh"

module timer2_capture_reload_baud
#(
	parameter SLOW_DIVIDE = `SLOW_TIMER_DIVIDE
)
(
	// clock, reset, enable
	input  wire       clk_i,
	input  wire       srst_i,
	input  wire       ce_i,
	// register port
	input  wire [7:0] addr_i,
	input  wire [7:0] wdata_i,
	input  wire       wr_i,
	input  wire       rd_i,
	output reg  [7:0] rdata_o,
	// pins and system inputs
	input  wire       external_trigger_pin_i,
	input  wire       count_input_pin_i,
	input  wire       timer_speed_select_i,
	input  wire       timer1_overflow_i,
	// outputs
	output wire       timer_irq_o,
	output wire       overflow_pulse_o,
	output wire       rx_baud_tick_o,
	output wire       tx_baud_tick_o
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	localparam        PIN_COUNT = 2;
	localparam        PIN_TRIG  = 0;
	localparam        PIN_CNT   = 1;
	localparam [31:0] SLOW_LAST = SLOW_DIVIDE - 1;

	reg  [7:0]           control_q;
	reg  [15:0]          reload_q;
	reg  [15:0]          count_q;
	reg                  baud_phase_q;
	reg  [3:0]           slow_cnt_q;
	reg  [7:0]           ctl_d;
	reg  [15:0]          reload_d;
	reg  [15:0]          count_d;
	reg                  baud_phase_d;
	reg  [3:0]           slow_cnt_d;
	reg  [7:0]           rdata_d;
	reg                  tick;
	wire [PIN_COUNT-1:0] pin_raw;
	wire [PIN_COUNT-1:0] pin_fall;
	wire [3:0]           slow_last;

	wire overflow_flag   = control_q[`BIT_OVERFLOW_FLAG];
	wire external_flag   = control_q[`BIT_EXTERNAL_FLAG];
	wire rx_sel          = control_q[`BIT_RECEIVE_CLOCK_SEL];
	wire tx_sel          = control_q[`BIT_TRANSMIT_CLOCK_SEL];
	wire external_enable = control_q[`BIT_EXTERNAL_ENABLE];
	wire run_bit         = control_q[`BIT_RUN];
	wire ct_sel          = control_q[`BIT_COUNTER_TIMER_SEL];
	wire cr_sel          = control_q[`BIT_CAPTURE_RELOAD_SEL];
	wire baud_mode       = rx_sel | tx_sel;

	// ----------------------------------------
	// pin synchronisers and edges
	// ----------------------------------------
	// every stage presets high, the idle pin level, so no false fall follows reset
	assign pin_raw = {count_input_pin_i, external_trigger_pin_i};

	genvar p;
	generate
		for (p = 0; p < PIN_COUNT; p = p + 1)
		begin : g_pin
			reg meta_q;
			reg sync_q;
			reg prev_q;

			always @(posedge clk_i)
			begin
				if (srst_i)
				begin
					meta_q <= 1'h1;
					sync_q <= 1'h1;
					prev_q <= 1'h1;
				end
				else if (ce_i)
				begin
					meta_q <= pin_raw[p];
					sync_q <= meta_q;
					prev_q <= sync_q;
				end
			end

			assign pin_fall[p] = prev_q & ~sync_q;
		end
	endgenerate

	wire trig_fall = pin_fall[PIN_TRIG];
	wire cnt_fall  = pin_fall[PIN_CNT];

	// ----------------------------------------
	// tick selection
	// ----------------------------------------
	// the slow divider free-runs so ticks stay evenly spaced; a fresh start may wait part of one
	assign slow_last = SLOW_LAST[3:0];
	wire slow_tick = (slow_cnt_q == slow_last);
	wire fast_tick = 1'h1;

	always @*
	begin
		tick = 1'h0;
		if (baud_mode)
		begin
			tick = baud_phase_q;
		end
		else if (ct_sel)
		begin
			tick = cnt_fall;
		end
		else if (timer_speed_select_i)
		begin
			tick = fast_tick;
		end
		else
		begin
			tick = slow_tick;
		end
	end

	// ----------------------------------------
	// timer events
	// ----------------------------------------
	wire advance      = run_bit & tick;
	wire wrap         = advance & (count_q == `COUNT_MAX);
	wire ext_edge     = trig_fall & external_enable & ~baud_mode;
	wire wrap_reload  = wrap & (baud_mode | ~cr_sel);
	wire edge_reload  = ext_edge & ~cr_sel;
	wire do_reload    = wrap_reload | edge_reload;
	wire do_capture   = ext_edge & cr_sel;
	wire set_overflow = wrap & ~baud_mode;
	wire set_external = trig_fall & external_enable;

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	wire wr_ctl  = wr_i & (addr_i == `ADDR_TIMER_CONTROL);
	wire wr_rl   = wr_i & (addr_i == `ADDR_RELOAD_CAPTURE_LOW);
	wire wr_rh   = wr_i & (addr_i == `ADDR_RELOAD_CAPTURE_HIGH);
	wire wr_cl   = wr_i & (addr_i == `ADDR_COUNT_LOW);
	wire wr_ch   = wr_i & (addr_i == `ADDR_COUNT_HIGH);

	// ----------------------------------------
	// control next state
	// ----------------------------------------
	always @*
	begin
		ctl_d = control_q;
		if (wr_ctl)
		begin
			ctl_d = wdata_i;
		end
		// hardware set beats a same-cycle software clear
		if (set_overflow)
		begin
			ctl_d[`BIT_OVERFLOW_FLAG] = 1'h1;
		end
		if (set_external)
		begin
			ctl_d[`BIT_EXTERNAL_FLAG] = 1'h1;
		end
	end

	// ----------------------------------------
	// reload next state
	// ----------------------------------------
	always @*
	begin
		reload_d = reload_q;
		if (wr_rl)
		begin
			reload_d[7:0] = wdata_i;
		end
		if (wr_rh)
		begin
			reload_d[15:8] = wdata_i;
		end
		// a capture wins over a same-cycle software write
		if (do_capture)
		begin
			reload_d = count_q;
		end
	end

	// ----------------------------------------
	// count next state
	// ----------------------------------------
	always @*
	begin
		count_d = count_q;
		if (do_reload)
		begin
			count_d = reload_q;
		end
		else if (advance)
		begin
			count_d = count_q + 16'h0001;
		end
		// software write to a count byte wins over counting
		if (wr_cl)
		begin
			count_d[7:0] = wdata_i;
		end
		if (wr_ch)
		begin
			count_d[15:8] = wdata_i;
		end
	end

	// ----------------------------------------
	// dividers next state
	// ----------------------------------------
	always @*
	begin
		baud_phase_d = ~baud_phase_q;
		if (slow_tick)
		begin
			slow_cnt_d = 4'h0;
		end
		else
		begin
			slow_cnt_d = slow_cnt_q + 4'h1;
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always @*
	begin
		rdata_d = 8'h00;
		if (!rd_i)
		begin
			rdata_d = 8'h00;
		end
		else if (addr_i == `ADDR_TIMER_CONTROL)
		begin
			rdata_d = control_q;
		end
		else if (addr_i == `ADDR_RELOAD_CAPTURE_LOW)
		begin
			rdata_d = reload_q[7:0];
		end
		else if (addr_i == `ADDR_RELOAD_CAPTURE_HIGH)
		begin
			rdata_d = reload_q[15:8];
		end
		else if (addr_i == `ADDR_COUNT_LOW)
		begin
			rdata_d = count_q[7:0];
		end
		else if (addr_i == `ADDR_COUNT_HIGH)
		begin
			rdata_d = count_q[15:8];
		end
		else
		begin
			rdata_d = 8'h00;
		end
	end

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			control_q <= `RESET_BYTE;
		end
		else if (ce_i)
		begin
			control_q <= ctl_d;
		end
	end

	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			reload_q <= {`RESET_BYTE, `RESET_BYTE};
		end
		else if (ce_i)
		begin
			reload_q <= reload_d;
		end
	end

	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			count_q <= {`RESET_BYTE, `RESET_BYTE};
		end
		else if (ce_i)
		begin
			count_q <= count_d;
		end
	end

	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			baud_phase_q <= 1'h0;
		end
		else if (ce_i)
		begin
			baud_phase_q <= baud_phase_d;
		end
	end

	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			slow_cnt_q <= 4'h0;
		end
		else if (ce_i)
		begin
			slow_cnt_q <= slow_cnt_d;
		end
	end

	// read data stands one cycle after the strobe, then returns to zero
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			rdata_o <= 8'h00;
		end
		else if (ce_i)
		begin
			rdata_o <= rdata_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// level interrupt request; enable lives in the interrupt controller outside
	assign timer_irq_o      = overflow_flag | external_flag;
	assign overflow_pulse_o = wrap;
	assign rx_baud_tick_o   = rx_sel ? wrap : timer1_overflow_i;
	assign tx_baud_tick_o   = tx_sel ? wrap : timer1_overflow_i;

endmodule

// ---- core/timer2_defs.vh ----
`ifndef TIMER2_DEFS_VH
`define TIMER2_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_TIMER_CONTROL      8'hC8
`define ADDR_RELOAD_CAPTURE_LOW 8'hCA
`define ADDR_RELOAD_CAPTURE_HIGH 8'hCB
`define ADDR_COUNT_LOW          8'hCC
`define ADDR_COUNT_HIGH         8'hCD

// ----------------------------------------
// timer_control fields
// ----------------------------------------
`define BIT_OVERFLOW_FLAG       7
`define BIT_EXTERNAL_FLAG       6
`define BIT_RECEIVE_CLOCK_SEL   5
`define BIT_TRANSMIT_CLOCK_SEL  4
`define BIT_EXTERNAL_ENABLE     3
`define BIT_RUN                 2
`define BIT_COUNTER_TIMER_SEL   1
`define BIT_CAPTURE_RELOAD_SEL  0

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RESET_BYTE              8'h00
`define COUNT_MAX               16'hFFFF
`define BAUD_DIVIDE             2
`define SLOW_TIMER_DIVIDE       12

`endif

// ---- core/unused_placeholder_none.v ----
`timescale 1ns/1ps

// ---- verification/timer2_capture_reload_baud_properties.sv ----
`timescale 1ns/1ps
// ----
// port checks
// ----
module timer2_props (
	input wire       clk_i,
	input wire       srst_i,
	input wire       ce_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire       wr_i,
	input wire       rd_i,
	input wire [7:0] rdata_o,
	input wire       timer1_overflow_i,
	input wire       timer_irq_o,
	input wire       overflow_pulse_o,
	input wire       rx_baud_tick_o,
	input wire       tx_baud_tick_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	AST_RX: assert property (rx_baud_tick_o |-> overflow_pulse_o || timer1_overflow_i)
		else $error("rx tick");
	AST_TX: assert property (tx_baud_tick_o |-> overflow_pulse_o || timer1_overflow_i)
		else $error("tx tick");
	// no tick that is only a wrap means both selects are zero
	AST_FLAG:
		assert property (overflow_pulse_o && !rx_baud_tick_o && !tx_baud_tick_o |=> timer_irq_o)
		else $error("flag not set");
	AST_CLEAR:
		assert property ($fell(timer_irq_o) |-> $past(wr_i) && $past(addr_i) == 8'hC8)
		else $error("flag lost");
	AST_BAUD:
		assert property (overflow_pulse_o && rx_baud_tick_o && !timer1_overflow_i |=> !overflow_pulse_o)
		else $error("baud rate");
	AST_RD_IDLE: assert property (ce_i && !rd_i |=> rdata_o == 8'h00)
		else $error("read idle");
	AST_RD_GAP: assert property (rd_i && addr_i == 8'hC9 |=> rdata_o == 8'h00)
		else $error("unmapped read");
	AST_SW_SET:
		assert property (wr_i && ce_i && addr_i == 8'hC8 && wdata_i[7:6] != 2'h0 |=> timer_irq_o)
		else $error("software set");
	cover property (overflow_pulse_o && !rx_baud_tick_o);
	cover property (overflow_pulse_o && rx_baud_tick_o);
	cover property ($rose(timer_irq_o));
endmodule

bind timer2_capture_reload_baud timer2_props chk_u (.clk_i, .srst_i, .ce_i, .addr_i, .wdata_i,
	.wr_i, .rd_i, .rdata_o, .timer1_overflow_i, .timer_irq_o, .overflow_pulse_o,
	.rx_baud_tick_o, .tx_baud_tick_o);

// ---- verification/pin_model.sv ----
`timescale 1ns/1ps
// ----
// trigger and count pins, idle high
// ----
module pin_model (
	input  wire  clk_i,
	output logic trig_o = 1'h1,
	output logic cnt_o = 1'h1
);
	// levels held two clocks or more, or the synchroniser may miss them
	task fall(input bit trig, input int hold);
		repeat (hold) @(posedge clk_i);
		if (trig)
			trig_o <= 1'h0;
		else
			cnt_o <= 1'h0;
		repeat (hold) @(posedge clk_i);
		trig_o <= 1'h1;
		cnt_o <= 1'h1;
	endtask
endmodule

// ---- verification/timer2_capture_reload_baud_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
	$display("FAIL %0t got %h want %h", $time, a, b); end end
module timer2_capture_reload_baud_tb;
	logic        clk_i, trig, cnt, irq, ovf, rxt, txt;
	logic        srst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, spd = 1'h1, t1 = 1'h0, ce = 1'h1;
	logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, rdata_o, sel;
	logic [15:0] r, v;
	integer      seed = 32075, miscompares = 0, checked = 0, i, k, n;
	logic [7:0]  adr [6] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
	timer2_capture_reload_baud #(.SLOW_DIVIDE(2)) dut_u (.clk_i, .srst_i, .ce_i(ce),
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .external_trigger_pin_i(trig),
		.count_input_pin_i(cnt), .timer_speed_select_i(spd), .timer1_overflow_i(t1),
		.timer_irq_o(irq), .overflow_pulse_o(ovf), .rx_baud_tick_o(rxt), .tx_baud_tick_o(txt));
	pin_model pm_u (.clk_i, .trig_o(trig), .cnt_o(cnt));
	initial
	begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) t1 <= 1'($random(seed));
	function integer per(input [15:0] rl);
		per = 2 * (32'h10000 - rl);
	endfunction
	task wr(input [7:0] a, d);
		@(posedge clk_i);
		wr_i <= 1'h1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'h0;
	endtask
	task rd(input [7:0] a, e);
		@(posedge clk_i);
		rd_i <= 1'h1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'h0;
		#1 `CHK(rdata_o, e)
	endtask
	task rd16(input [7:0] a, input [15:0] e);
		rd(a, e[7:0]);
		rd(a + 8'h1, e[15:8]);
	endtask
	task ld(input [15:0] rl, c);
		wr(8'hCA, rl[7:0]);
		wr(8'hCB, rl[15:8]);
		wr(8'hCC, c[7:0]);
		wr(8'hCD, c[15:8]);
	endtask
	// bounded, so a wrap that never comes ends as a mismatch
	task wait_ovf;
		n = 0;
		do
		begin
			@(negedge clk_i);
			n++;
		end while (!ovf && n < 600);
		`CHK(ovf, 1'h1)
	endtask
	task results;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#200000;
		miscompares++;
		results;
	end
	initial
	begin
		repeat (10) @(posedge clk_i);
		srst_i <= 1'h0;
		for (i = 0; i < 6; i++)
			rd(adr[i], 8'h00);
		for (i = 2; i < 6; i++)
		begin
			v = 16'($random(seed));
			wr(adr[i], v[7:0]);
			rd(adr[i], v[7:0]);
		end
		$display("test registers done");
		r = 16'($random(seed)) & 16'h7FFF;
		ld(r, 16'hFFF0);
		wr(8'hC8, 8'h04);
		wait_ovf;
		wr(8'hC8, 8'h80);
		rd16(8'hCC, r + 16'h1);
		rd(8'hC8, 8'h80);
		for (i = 0; i < 3; i++)
		begin
			sel = {i == 1, i == 2, 6'h00};
			wr(8'hC8, sel);
			#1 `CHK(irq, |sel)
		end
		$display("test overflow done");
		ld(16'h0000, 16'h0000);
		spd <= 1'h1;
		wr(8'hC8, 8'h04);
		ce <= 1'h0;
		repeat (1 + {$random(seed)} % 8) @(posedge clk_i);
		ce <= 1'h1;
		wr(8'hC8, 8'h00);
		rd16(8'hCC, 16'h0002);
		$display("test clock enable done");
		ld(r, 16'h0000);
		spd <= 1'($random(seed));
		wr(8'hC8, 8'h06);
		k = 1 + {$random(seed)} % 6;
		repeat (k) pm_u.fall(0, 2 + {$random(seed)} % 3);
		repeat (4) @(posedge clk_i);
		wr(8'hC8, 8'h00);
		rd16(8'hCC, k[15:0]);
		for (i = 0; i < 3; i++)
		begin
			sel = i == 0 ? 8'h09 : i == 1 ? 8'h08 : 8'h00;
			r = 16'($random(seed));
			v = 16'($random(seed));
			ld(r, v);
			wr(8'hC8, sel);
			pm_u.fall(1, 2);
			repeat (4) @(posedge clk_i);
			rd16(8'hCA, sel[0] ? v : r);
			rd16(8'hCC, sel == 8'h08 ? r : v);
			rd(8'hC8, sel | {1'h0, sel[3], 6'h00});
		end
		$display("test trigger done");
		for (i = 0; i < 2; i++)
		begin
			sel = i ? 8'h15 : 8'h25;
			r = {8'hFF, 8'($random(seed))};
			ld(r, r);
			wr(8'hC8, sel);
			wait_ovf;
			wait_ovf;
			`CHK(n, per(r))
			`CHK(rxt, sel[5] ? 1'h1 : t1)
			`CHK(txt, sel[4] ? 1'h1 : t1)
			`CHK(irq, 1'h0)
		end
		$display("test baud done");
		results;
	end
endmodule
